// [kldc_pkg.sv]
// Package for the keypad LED dimming controller: register map, field
// positions, reset values and timing constants.
// Assumes a 125 MHz reference clock and 8-bit register accesses.
package kldc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int             KLDC_AW           = 8;
    localparam int             KLDC_DW           = 8;
    localparam int             KLDC_NOUT         = 3;
    localparam logic [7:0]     KLDC_ADDR_CTRL    = 8'h00;
    localparam logic [7:0]     KLDC_ADDR_KEYPAD  = 8'h01;
    localparam logic [7:0]     KLDC_ADDR_EXTSEL  = 8'h03;
    localparam logic [7:0]     KLDC_ADDR_STATUS  = 8'h04;

    // Control register fields
    localparam int             KLDC_CTL_DRIVE_EN = 0;
    localparam int             KLDC_CTL_DIM_SEL  = 1;
    localparam int             KLDC_CTL_DRV_MODE = 2;
    localparam int             KLDC_CTL_ON_LSB   = 3;

    // Keypad brightness and balance register fields
    localparam int             KLDC_KP_OVL       = 0;
    localparam int             KLDC_KP_BRT_LSB   = 1;
    localparam int             KLDC_KP_BAL_LSB   = 4;
    localparam int             KLDC_KP_FLD_W     = 3;

    // External gate select and boost enable register fields
    localparam int             KLDC_EXT_GATE_LSB = 0;
    localparam int             KLDC_BOOST_EN_BIT = 3;

    // Status register fields
    localparam int             KLDC_ST_BLANK     = 0;
    localparam int             KLDC_ST_EXT       = 1;
    localparam int             KLDC_ST_SINK_LSB  = 2;

    // Reset values; switch drive is the power-on default
    localparam logic [7:0]     KLDC_CTRL_RST     = 8'h04;
    localparam logic [7:0]     KLDC_KEYPAD_RST   = 8'h00;
    localparam logic [7:0]     KLDC_EXTSEL_RST   = 8'h00;

    // ------------------------------------------------------------
    // Brightness and balance
    // ------------------------------------------------------------
    localparam int             KLDC_BRT_MAX      = 7;
    localparam int             KLDC_BAL_FULL     = 12;
    // Cumulative slot ends in twelfths of the lit window, {third,second,first}
    localparam logic [11:0]    KLDC_BAL_TABLE [8] = '{
        12'hCCC, 12'hCC0, 12'hC00, 12'hCC6,
        12'hC60, 12'hC66, 12'hC84, 12'hC96
    };

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int             KLDC_CLK_MHZ      = 125;
    localparam int             KLDC_FRAME_US     = 50;
    localparam int             KLDC_FRAME_CYC    = KLDC_FRAME_US * KLDC_CLK_MHZ;
    localparam int             KLDC_BOOST_MS     = 20;
    localparam int             KLDC_BOOST_CYC    = KLDC_BOOST_MS * 1000 * KLDC_CLK_MHZ;

endpackage

// [kldc_frame_if.sv]
// Interface carrying the PWM frame position between the frame timer
// and the dimming logic.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface kldc_frame_if #(
    parameter int CW = 13
);
    logic [CW-1:0] pos;
    logic          frame_end;

    modport timer (output pos, output frame_end);
    modport user  (input pos, input frame_end);
endinterface

// [kldc_frame_timer.sv]
// Free-running PWM frame counter for the keypad dimming logic.
// Assumes a frame length given in reference clock cycles.
`timescale 1ns/1ns
module kldc_frame_timer import kldc_pkg::*; #(
    parameter int FRAME_CYC = KLDC_FRAME_CYC,
    parameter int CW        = $clog2(KLDC_FRAME_CYC + 1)
)(
    input  wire logic   ref_clk_i,
    input  wire logic   rst_i,
    kldc_frame_if.timer frm
);
    localparam logic [CW-1:0] LAST = CW'(FRAME_CYC - 1);

    logic [CW-1:0] pos_r;

    // ------------------------------------------------------------
    // Frame counter
    // ------------------------------------------------------------
    // Wraps every frame; taken straight from the oscillator clock
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos_r <= '0;
        end else if (pos_r == LAST) begin
            pos_r <= '0;
        end else begin
            pos_r <= pos_r + 1'b1;
        end
    end

    // Last cycle of a frame, used to latch new settings
    assign frm.pos       = pos_r;
    assign frm.frame_end = (pos_r == LAST);

endmodule

// [kldc_top.sv]
// Keypad LED dimming controller: control registers, logarithmic
// brightness PWM, balance slots, external PWM gating, boost blanking.
// Assumes an upstream serial front end that turns host accesses into
// single-cycle register strobes, and ext_pwm_i arriving asynchronously.
`timescale 1ns/1ns
module kldc_top import kldc_pkg::*; #(
    parameter int FRAME_CYC = KLDC_FRAME_CYC,
    parameter int BOOST_CYC = KLDC_BOOST_CYC
)(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    input  wire logic [KLDC_AW-1:0] reg_addr_i,
    input  wire logic [KLDC_DW-1:0] reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [KLDC_DW-1:0] reg_rdata_o,
    input  wire logic               ext_pwm_i,
    output logic                    first_keypad_sink_o,
    output logic                    second_keypad_sink_o,
    output logic                    third_keypad_sink_o,
    output logic                    output_drive_select_o,
    output logic                    boost_blank_o
);
    localparam int              CW       = $clog2(FRAME_CYC + 1);
    localparam int              BW       = $clog2(BOOST_CYC + 1);
    localparam logic [CW-1:0]   FRAME_W  = CW'(FRAME_CYC);
    localparam logic [CW+3:0]   FULL_W   = (CW + 4)'(KLDC_BAL_FULL);
    localparam logic [2:0]      BRT_MAX  = 3'(KLDC_BRT_MAX);
    localparam logic [BW-1:0]   BOOST_LD = BW'(BOOST_CYC - 1);
    localparam int              LAST_POS = FRAME_CYC - 1;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Lit window length for a brightness code, doubling per step
    function automatic logic [CW-1:0] win_len(input logic [2:0] code);
        logic [CW-1:0] w;
        w = '0;
        if (code != 3'h0) begin
            w = FRAME_W >> (BRT_MAX - code);
        end
        return w;
    endfunction

    // Share of the lit window in twelfths, rounded down
    function automatic logic [CW-1:0] bnd(input logic [CW-1:0] w,
                                          input logic [3:0]    e);
        logic [CW+3:0] p;
        p = (CW + 4)'(w) * (CW + 4)'(e);
        p = p / FULL_W;
        return p[CW-1:0];
    endfunction

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [KLDC_DW-1:0]   ctrl_r;
    logic [KLDC_DW-1:0]   keypad_r;
    logic [KLDC_DW-1:0]   extsel_r;
    logic [KLDC_DW-1:0]   rdata_r;
    logic [2:0]           sync_r;
    logic                 ext_lvl_r;
    logic                 boost_prev_r;
    logic                 blank_r;
    logic [BW-1:0]        boost_cnt_r;
    logic [CW-1:0]        win_r;
    logic                 ovl_r;
    logic [CW-1:0]        end_r [KLDC_NOUT];
    logic [KLDC_NOUT-1:0] sink_r;
    logic [KLDC_NOUT-1:0] on_nxt;
    logic [KLDC_NOUT-1:0] int_on;
    logic [KLDC_NOUT-1:0] out_en;
    logic [KLDC_NOUT-1:0] ext_sel;
    logic                 drive_en;
    logic                 dim_sel;
    logic                 boost_en;
    logic [11:0]          bal_ends;

    kldc_frame_if #(.CW(CW)) frm ();

    kldc_frame_timer #(
        .FRAME_CYC (FRAME_CYC),
        .CW        (CW)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .frm       (frm)
    );

    // Field views of the software registers
    assign drive_en = ctrl_r[KLDC_CTL_DRIVE_EN];
    assign dim_sel  = ctrl_r[KLDC_CTL_DIM_SEL];
    assign out_en   = ctrl_r[KLDC_CTL_ON_LSB +: KLDC_NOUT];
    assign ext_sel  = extsel_r[KLDC_EXT_GATE_LSB +: KLDC_NOUT];
    assign boost_en = extsel_r[KLDC_BOOST_EN_BIT];

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Writes to unmapped addresses are dropped silently
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r   <= KLDC_CTRL_RST;
            keypad_r <= KLDC_KEYPAD_RST;
            extsel_r <= KLDC_EXTSEL_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == KLDC_ADDR_CTRL) begin
                ctrl_r <= reg_wdata_i;
            end else if (reg_addr_i == KLDC_ADDR_KEYPAD) begin
                keypad_r <= reg_wdata_i;
            end else if (reg_addr_i == KLDC_ADDR_EXTSEL) begin
                extsel_r <= reg_wdata_i;
            end
        end
    end

    // Read data is registered; unmapped reads return zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (reg_rd_i) begin
            if (reg_addr_i == KLDC_ADDR_CTRL) begin
                rdata_r <= ctrl_r;
            end else if (reg_addr_i == KLDC_ADDR_KEYPAD) begin
                rdata_r <= keypad_r;
            end else if (reg_addr_i == KLDC_ADDR_EXTSEL) begin
                rdata_r <= extsel_r;
            end else if (reg_addr_i == KLDC_ADDR_STATUS) begin
                rdata_r                                   <= '0;
                rdata_r[KLDC_ST_BLANK]                    <= blank_r;
                rdata_r[KLDC_ST_EXT]                      <= ext_lvl_r;
                rdata_r[KLDC_ST_SINK_LSB +: KLDC_NOUT]    <= sink_r;
            end else begin
                rdata_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // External PWM input
    // ------------------------------------------------------------
    // Three stages; a level counts only once stages two and three agree,
    // which also rejects a single-cycle glitch on the pin
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_r    <= '0;
            ext_lvl_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], ext_pwm_i};
            if (sync_r[1] == sync_r[2]) begin
                ext_lvl_r <= sync_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Boost startup blanking
    // ------------------------------------------------------------
    // Enable going high starts the delay; dropping it cancels the wait
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boost_prev_r <= 1'b0;
            blank_r      <= 1'b0;
            boost_cnt_r  <= '0;
        end else begin
            boost_prev_r <= boost_en;
            if (boost_en && !boost_prev_r) begin
                blank_r     <= 1'b1;
                boost_cnt_r <= BOOST_LD;
            end else if (!boost_en) begin
                blank_r     <= 1'b0;
                boost_cnt_r <= '0;
            end else if (blank_r) begin
                if (boost_cnt_r == '0) begin
                    blank_r <= 1'b0;
                end else begin
                    boost_cnt_r <= boost_cnt_r - 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Frame-latched dimming settings
    // ------------------------------------------------------------
    assign bal_ends = KLDC_BAL_TABLE[keypad_r[KLDC_KP_BAL_LSB +: KLDC_KP_FLD_W]];

    // Taken only on the last cycle so no pulse is ever cut or doubled
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_r <= '0;
            ovl_r <= 1'b0;
            for (int k = 0; k < KLDC_NOUT; k++) begin
                end_r[k] <= '0;
            end
        end else if (frm.frame_end) begin
            win_r <= win_len(keypad_r[KLDC_KP_BRT_LSB +: KLDC_KP_FLD_W]);
            ovl_r <= keypad_r[KLDC_KP_OVL];
            for (int k = 0; k < KLDC_NOUT; k++) begin
                end_r[k] <= bnd(win_len(keypad_r[KLDC_KP_BRT_LSB +: KLDC_KP_FLD_W]),
                                bal_ends[4*k +: 4]);
            end
        end
    end

    // ------------------------------------------------------------
    // Internal PWM and output selection
    // ------------------------------------------------------------
    // Without overlap, slots sit back to back in the compressed window; with overlap all share it; rest of frame off
    always_comb begin
        for (int k = 0; k < KLDC_NOUT; k++) begin
            if (ovl_r) begin
                int_on[k] = (frm.pos < win_r);
            end else if (k == 0) begin
                int_on[k] = (frm.pos < end_r[k]);
            end else begin
                int_on[k] = (frm.pos >= end_r[k-1]) && (frm.pos < end_r[k]);
            end
        end
    end

    // Per-output gating; blanking overrides everything
    always_comb begin
        for (int k = 0; k < KLDC_NOUT; k++) begin
            on_nxt[k] = 1'b0;
            if (!blank_r && drive_en && out_en[k]) begin
                if (dim_sel) begin
                    on_nxt[k] = int_on[k];
                end else begin
                    on_nxt[k] = 1'b1;
                end
                if (ext_sel[k]) begin
                    on_nxt[k] = on_nxt[k] & ext_lvl_r;
                end
            end
        end
    end

    // Registered pin drive, one cycle behind the selection logic
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sink_r                <= '0;
            output_drive_select_o <= KLDC_CTRL_RST[KLDC_CTL_DRV_MODE];
        end else begin
            sink_r                <= on_nxt;
            output_drive_select_o <= ctrl_r[KLDC_CTL_DRV_MODE];
        end
    end

    assign first_keypad_sink_o  = sink_r[0];
    assign second_keypad_sink_o = sink_r[1];
    assign third_keypad_sink_o  = sink_r[2];
    assign boost_blank_o        = blank_r;
    assign reg_rdata_o          = rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_drive_mode_follow: assert property (
        ##1 output_drive_select_o == $past(ctrl_r[KLDC_CTL_DRV_MODE]))
        else $error("drive select output does not follow control bit");

    a_dim_needs_enable: assert property (
        !drive_en |=> sink_r == '0)
        else $error("output lit with keypad drive disabled");

    a_enable_gates_out: assert property (
        !out_en[1] |=> !second_keypad_sink_o)
        else $error("second output lit while its enable is low");

    a_slots_disjoint: assert property (
        (dim_sel && !ovl_r && !(|ext_sel)) |-> $onehot0(on_nxt))
        else $error("non-overlapping slots overlap");

    a_zero_code_off: assert property (
        (dim_sel && win_r == '0) |=> sink_r == '0)
        else $error("brightness code zero lights an output");

    a_overlap_together: assert property (
        (dim_sel && ovl_r && drive_en && out_en[0] && out_en[2] && !blank_r
         && ext_sel == '0) |=> first_keypad_sink_o == third_keypad_sink_o)
        else $error("overlap outputs not switched together");

    a_frame_wrap: assert property (
        (frm.pos == CW'(LAST_POS)) |=> (frm.pos == '0) ##1 (frm.pos == CW'(1)))
        else $error("frame counter does not wrap at frame length");

    a_settings_hold: assert property (
        !frm.frame_end |=> $stable(win_r) && $stable(ovl_r))
        else $error("dimming settings changed inside a frame");

    a_blank_all_off: assert property (
        blank_r |=> sink_r == '0)
        else $error("output lit during boost startup delay");

    a_direct_follow: assert property (
        (drive_en && !dim_sel && !blank_r && !ext_sel[0])
        |=> first_keypad_sink_o == $past(out_en[0]))
        else $error("direct mode output does not follow its enable");

    a_ext_masks_out: assert property (
        (ext_sel[2] && !ext_lvl_r) |=> !third_keypad_sink_o)
        else $error("gated output lit while external input low");

    c_overlap_lit: cover property (ovl_r && sink_r == 3'b111);
    c_slot_handover: cover property (first_keypad_sink_o ##1 second_keypad_sink_o);
    c_blank_release: cover property ($fell(blank_r));

endmodule

// [kldc_ext_pwm_src.sv]
// External PWM source model feeding the keypad dimming controller.
// Assumes it runs from the same reference clock; period divides the frame.
`timescale 1ns/1ns
module kldc_ext_pwm_src #(
    parameter int PERIOD = 16,
    parameter int HIGH   = 8
)(
    input  wire logic ref_clk_i,
    input  wire logic en_i,
    output logic      pwm_o
);
    int cnt_r = 0;

    // ------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------
    // Source released drives low, so a stale high never leaks through
    always_ff @(posedge ref_clk_i) begin
        cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
        pwm_o <= en_i && (cnt_r < HIGH);
    end
endmodule

// [tb_keypad_led_dimming_controller.sv]
// Self-checking bench for the keypad LED dimming controller top.
// Assumes shortened frame and boost counts; external PWM from a model.
`timescale 1ns/1ns
module tb_keypad_led_dimming_controller;
    import kldc_pkg::*;
    localparam int FR = 128;
    localparam int BC = 20;
    typedef struct {logic [7:0] c, k, x; int e1, e2, e3;} kldc_row_type;

    logic       ref_clk_i   = 1'b0;
    logic       rst_i       = 1'b1;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic       ext_en      = 1'b0;
    logic [7:0] reg_addr_i  = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] rd;
    wire  logic [7:0] reg_rdata_o;
    wire  logic ext_pwm, sink1, sink2, sink3, drv_sel, blank;
    int num_errors = 0;
    int checked    = 0;
    int n1, n2, n3, nd, nb, nv;

    // Ordinary cases: ctrl, keypad, extsel and on-cycles per frame
    kldc_row_type rows [22] = '{
        '{8'h3B, 8'h0E, 8'h00, 128, 0, 0},
        '{8'h3B, 8'h1E, 8'h00, 0, 128, 0},
        '{8'h3B, 8'h2E, 8'h00, 0, 0, 128},
        '{8'h3B, 8'h3E, 8'h00, 64, 64, 0},
        '{8'h3B, 8'h4E, 8'h00, 0, 64, 64},
        '{8'h3B, 8'h5E, 8'h00, 64, 0, 64},
        '{8'h3B, 8'h6E, 8'h00, 42, 43, 43},
        '{8'h3B, 8'h7E, 8'h00, 64, 32, 32},
        '{8'h3B, 8'h00, 8'h00, 0, 0, 0},
        '{8'h3B, 8'h02, 8'h00, 2, 0, 0},
        '{8'h3B, 8'h04, 8'h00, 4, 0, 0},
        '{8'h3B, 8'h06, 8'h00, 8, 0, 0},
        '{8'h3B, 8'h08, 8'h00, 16, 0, 0},
        '{8'h3B, 8'h0A, 8'h00, 32, 0, 0},
        '{8'h3B, 8'h0C, 8'h00, 64, 0, 0},
        '{8'h3B, 8'h6B, 8'h00, 32, 32, 32},
        '{8'h2B, 8'h0F, 8'h00, 128, 0, 128},
        '{8'h3A, 8'h0E, 8'h00, 0, 0, 0},
        '{8'h39, 8'h0E, 8'h00, 128, 128, 128},
        '{8'h19, 8'h00, 8'h00, 128, 128, 0},
        '{8'h39, 8'h00, 8'h07, 64, 64, 64},
        '{8'h3B, 8'h0D, 8'h07, 32, 32, 32}
    };

    always #4 ref_clk_i = ~ref_clk_i;

    kldc_top #(.FRAME_CYC(FR), .BOOST_CYC(BC)) dut_u (
        .ref_clk_i            (ref_clk_i),
        .rst_i                (rst_i),
        .reg_addr_i           (reg_addr_i),
        .reg_wdata_i          (reg_wdata_i),
        .reg_wr_i             (reg_wr_i),
        .reg_rd_i             (reg_rd_i),
        .reg_rdata_o          (reg_rdata_o),
        .ext_pwm_i            (ext_pwm),
        .first_keypad_sink_o  (sink1),
        .second_keypad_sink_o (sink2),
        .third_keypad_sink_o  (sink3),
        .output_drive_select_o(drv_sel),
        .boost_blank_o        (blank)
    );

    kldc_ext_pwm_src src_u (.ref_clk_i(ref_clk_i), .en_i(ext_en), .pwm_o(ext_pwm));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chkn(input int g, input int e, input string m);
        checked++;
        if (g != e) begin
            num_errors++;
            $display("Error %0t: %s got %0d exp %0d", $time, m, g, e);
        end
    endtask

    // One-cycle strobes; next access waits a further edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Window of n cycles; on-counts are phase free over a whole frame
    // Sinks are one flop behind the blank flag, so lit-while-blank uses its last value
    task automatic count(input int n);
        logic pb;
        n1 = 0; n2 = 0; n3 = 0; nd = 0; nb = 0; nv = 0;
        pb = 1'b0;
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            n1 += (sink1 === 1'b1);
            n2 += (sink2 === 1'b1);
            n3 += (sink3 === 1'b1);
            nd += (sink1 !== sink2) || (sink2 !== sink3);
            nb += (blank === 1'b1);
            nv += (pb === 1'b1) && ({sink1, sink2, sink3} !== 3'b000);
            pb = blank;
        end
    endtask

    // Waits for a falling edge of sink k; t is cycles taken
    task automatic after_fall(input int k, output int t);
        logic p;
        logic c;
        p = 1'b0;
        for (t = 1; t < 4 * FR; t++) begin
            @(posedge ref_clk_i);
            #1;
            c = (k == 1) ? sink1 : sink2;
            if (p === 1'b1 && c === 1'b0) break;
            p = c;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk8({7'b0, drv_sel}, 8'h01, "drive at reset");
        chk8({5'b0, sink3, sink2, sink1}, 8'h00, "sinks at reset");
        rdr(KLDC_ADDR_CTRL, rd);
        chk8(rd, KLDC_CTRL_RST, "ctrl reset");
        rdr(KLDC_ADDR_KEYPAD, rd);
        chk8(rd, KLDC_KEYPAD_RST, "keypad reset");
        wr(KLDC_ADDR_KEYPAD, 8'h5D);
        rdr(KLDC_ADDR_KEYPAD, rd);
        chk8(rd, 8'h5D, "keypad readback");
        wr(8'h02, 8'hFF);
        rdr(8'h02, rd);
        chk8(rd, 8'h00, "unmapped read");
        // Table rows: settle two frames, then one whole frame counted
        foreach (rows[i]) begin
            wr(KLDC_ADDR_CTRL, rows[i].c);
            wr(KLDC_ADDR_KEYPAD, rows[i].k);
            wr(KLDC_ADDR_EXTSEL, rows[i].x);
            ext_en <= (rows[i].x != 8'h00);
            repeat (2 * FR + 8) @(posedge ref_clk_i);
            count(FR);
            chkn(n1, rows[i].e1, "first on-time");
            chkn(n2, rows[i].e2, "second on-time");
            chkn(n3, rows[i].e3, "third on-time");
            chk8({7'b0, drv_sel}, {7'b0, rows[i].c[2]}, "drive mode");
            if (rows[i].k[0] && rows[i].c == 8'h3B) chkn(nd, 0, "joint switching");
        end
        // Slot order and frame period with thirds balance
        wr(KLDC_ADDR_KEYPAD, 8'h6E);
        wr(KLDC_ADDR_EXTSEL, 8'h00);
        ext_en <= 1'b0;
        repeat (2 * FR) @(posedge ref_clk_i);
        after_fall(1, n1);
        chk8({6'b0, sink3, sink2}, 8'h01, "second follows first");
        after_fall(2, n1);
        chk8({6'b0, sink3, sink2}, 8'h02, "third follows second");
        after_fall(1, n1);
        after_fall(1, n1);
        chkn(n1, FR, "frame period");
        // Mid-frame change must wait for the frame end
        after_fall(1, n1);
        wr(KLDC_ADDR_KEYPAD, 8'h0E);
        count(80);
        chkn(n1, 0, "early apply");
        chkn(n2 + n3, 80, "old slots kept");
        // Boost start blanks direct-on outputs for the delay
        wr(KLDC_ADDR_CTRL, 8'h39);
        repeat (8) @(posedge ref_clk_i);
        fork
            wr(KLDC_ADDR_EXTSEL, 8'h08);
            count(40);
        join
        chkn(nb, BC, "blank length");
        chkn(nv, 0, "lit while blank");
        chk8({5'b0, sink3, sink2, sink1}, 8'h07, "released after blank");
        rdr(KLDC_ADDR_STATUS, rd);
        chk8(rd, 8'h1C, "status after blank");
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 10k cycles
    initial begin
        #400000;
        num_errors++;
        $display("Error %0t: timeout", $time);
        end_of_test();
    end
endmodule
